//--- rtl/seis_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module seis_fifo
  import seis_pkg::*;
#(
  parameter int Width = FIFO_W,
  parameter int Depth = FIFO_DEPTH
)
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [Width-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [Width-1:0]      outData
);
  localparam int AW = $clog2(Depth);

  logic [Width-1:0] store [Depth];
  logic [AW:0]      wrPtr;
  logic [AW:0]      rdPtr;
  logic             doPush;
  logic             doPop;

  // The extra pointer bit tells a full buffer from an empty one.
  assign outValid = (wrPtr != rdPtr);
  assign inReady  = !((wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]));
  assign doPush   = inValid && inReady;
  assign doPop    = outValid && outReady;
  assign outData  = store[rdPtr[AW-1:0]];

  always_ff @(posedge clk)
  begin
    if (rst)
      wrPtr <= '0;
    else if (doPush)
    begin
      store[wrPtr[AW-1:0]] <= inData;
      wrPtr <= wrPtr + (AW+1)'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      rdPtr <= '0;
    else if (doPop)
      rdPtr <= rdPtr + (AW+1)'(1);
  end
endmodule
`default_nettype wire

//--- rtl/seis_pkg.sv
`default_nettype none
package seis_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int SPIKE_FILTER_WIDTH_NS = 50;
  localparam int SPIKE_CYC = (SPIKE_FILTER_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TX_HOLD_NS = 300;
  localparam int TX_HOLD_CYC = (TX_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_TIME_MS = 5;
  localparam int WRITE_CYC = (WRITE_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int WC_W = 18;
  localparam int MEM_DEPTH = 256;
  localparam int PAGE_BYTES = 8;
  localparam int FIFO_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam logic [3:0] CTRL_CODE = 4'hA;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  localparam logic [2:0] LAST_PAGE_IDX = 3'h7;
  localparam logic [7:0] MEM_RESET = 8'hFF;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RECV = 5'h02,
    ST_ACK  = 5'h04,
    ST_SEND = 5'h08,
    ST_MACK = 5'h10
  } seis_state_t;

  typedef enum logic [2:0] {
    PH_CTRL = 3'h1,
    PH_ADDR = 3'h2,
    PH_DATA = 3'h4
  } seis_phase_t;
endpackage
`default_nettype wire

//--- rtl/seis_slave.sv
`timescale 1ns/10ps
`default_nettype none
module seis_slave
  import seis_pkg::*;
#(
  parameter int WriteCycles = WRITE_CYC,
  parameter int HoldCycles  = TX_HOLD_CYC
)
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic sclIn,
  input  wire logic sdaIn,
  output logic      sdaOut,
  output logic      sdaOe,
  input  wire logic wpIn,
  output logic      writeBusy
);
  localparam int SPK_W = $clog2(SPIKE_CYC + 1);
  localparam int HW = $clog2(HoldCycles + 1);

  logic [1:0]      pinRaw;
  logic [1:0]      syncA;
  logic [1:0]      syncB;
  logic [1:0]      filt;
  logic [1:0]      filtPrev;
  logic            wpA;
  logic            wpB;
  logic            sclF;
  logic            sdaF;
  logic            sclRise;
  logic            sclFall;
  logic            startEv;
  logic            stopEv;
  seis_state_t     state;
  seis_phase_t     phase;
  logic [3:0]      bitCnt;
  logic [7:0]      rxShift;
  logic [7:0]      txShift;
  logic            readOp;
  logic            wantLow;
  logic            masterAck;
  logic [HW-1:0]   holdCnt;
  logic            holdDone;
  logic [7:0]      ptr;
  logic [7:0]      mem [MEM_DEPTH];
  logic [7:0]      pageData [PAGE_BYTES];
  logic [7:0]      pageValid;
  logic [4:0]      pageBase;
  logic            byteDone;
  logic            ctrlMatch;
  logic            storeByte;
  logic            loadTx;
  logic            commitGo;
  logic            committing;
  logic [2:0]      commitIdx;
  logic            commitPush;
  logic            commitAdvance;
  logic            commitDone;
  logic            busy;
  logic [WC_W-1:0] wcCnt;
  logic            wcEnd;
  logic            fifoInReady;
  logic            fifoOutValid;
  logic [15:0]     fifoOutData;

  assign pinRaw = {sclIn, sdaIn};

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      syncA <= 2'h3;
      syncB <= 2'h3;
      wpA   <= 1'b1;
      wpB   <= 1'b1;
    end
    else
    begin
      syncA <= pinRaw;
      syncB <= syncA;
      wpA   <= wpIn;
      wpB   <= wpA;
    end
  end

  // A new level is taken only after it has held for the whole filter width.
  for (genvar g = 0; g < 2; g++)
  begin : gFilter
    logic [SPK_W-1:0] spikeCnt;
    always_ff @(posedge clk)
    begin
      if (rst)
      begin
        spikeCnt <= '0;
        filt[g]  <= 1'b1;
      end
      else if (syncB[g] != filt[g])
      begin
        if (spikeCnt == SPK_W'(SPIKE_CYC - 1))
        begin
          filt[g]  <= syncB[g];
          spikeCnt <= '0;
        end
        else
          spikeCnt <= spikeCnt + SPK_W'(1);
      end
      else
        spikeCnt <= '0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      filtPrev <= 2'h3;
    else
      filtPrev <= filt;
  end

  assign sclF    = filt[1];
  assign sdaF    = filt[0];
  assign sclRise = sclF && !filtPrev[1];
  assign sclFall = !sclF && filtPrev[1];
  assign startEv = sclF && filtPrev[1] && filtPrev[0] && !sdaF;
  assign stopEv  = sclF && filtPrev[1] && !filtPrev[0] && sdaF;

  assign byteDone  = sclFall && (state == ST_RECV) && (bitCnt == BYTE_BITS);
  assign ctrlMatch = (rxShift[7:4] == CTRL_CODE) && !busy;
  assign storeByte = byteDone && (phase == PH_DATA);
  assign loadTx    = sclFall && (((state == ST_ACK) && readOp) ||
                                 ((state == ST_MACK) && masterAck));

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state     <= ST_IDLE;
      phase     <= PH_CTRL;
      bitCnt    <= '0;
      rxShift   <= '0;
      txShift   <= '0;
      readOp    <= 1'b0;
      wantLow   <= 1'b0;
      masterAck <= 1'b0;
    end
    else if (startEv)
    begin
      state   <= ST_RECV;
      phase   <= PH_CTRL;
      bitCnt  <= '0;
      readOp  <= 1'b0;
      wantLow <= 1'b0;
    end
    else if (stopEv)
    begin
      state   <= ST_IDLE;
      bitCnt  <= '0;
      wantLow <= 1'b0;
    end
    else if (loadTx)
    begin
      state   <= ST_SEND;
      txShift <= mem[ptr];
      wantLow <= !mem[ptr][7];
      bitCnt  <= '0;
    end
    else
    begin
      case (state)
        ST_RECV:
        begin
          if (sclRise && (bitCnt != BYTE_BITS))
          begin
            rxShift <= {rxShift[6:0], sdaF};
            bitCnt  <= bitCnt + 4'h1;
          end
          else if (byteDone)
          begin
            if ((phase == PH_CTRL) && !ctrlMatch)
              state <= ST_IDLE;
            else
            begin
              state   <= ST_ACK;
              wantLow <= 1'b1;
            end
            if (phase == PH_CTRL)
              readOp <= rxShift[0];
          end
        end
        ST_ACK:
        begin
          if (sclFall)
          begin
            state   <= ST_RECV;
            bitCnt  <= '0;
            wantLow <= 1'b0;
            phase   <= (phase == PH_CTRL) ? PH_ADDR : PH_DATA;
          end
        end
        ST_SEND:
        begin
          if (sclFall)
          begin
            if (bitCnt == LAST_TX_BIT)
            begin
              state   <= ST_MACK;
              wantLow <= 1'b0;
              bitCnt  <= '0;
            end
            else
            begin
              txShift <= {txShift[6:0], 1'b0};
              wantLow <= !txShift[6];
              bitCnt  <= bitCnt + 4'h1;
            end
          end
        end
        ST_MACK:
        begin
          if (sclRise)
            masterAck <= !sdaF;
          else if (sclFall)
            state <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // The line may only move once the falling clock edge is well behind us.
  always_ff @(posedge clk)
  begin
    if (rst)
      holdCnt <= '0;
    else if (sclFall)
      holdCnt <= '0;
    else if (!holdDone)
      holdCnt <= holdCnt + HW'(1);
  end

  assign holdDone = (holdCnt == HW'(HoldCycles));

  always_ff @(posedge clk)
  begin
    if (rst)
      sdaOe <= 1'b0;
    else if (holdDone && !sclF)
      sdaOe <= wantLow;
  end

  assign sdaOut = 1'b0;

  always_ff @(posedge clk)
  begin
    if (rst)
      ptr <= '0;
    else if (byteDone && (phase == PH_ADDR))
      ptr <= rxShift;
    else if (storeByte)
      ptr <= {ptr[7:3], ptr[2:0] + 3'h1};
    else if (loadTx)
      ptr <= ptr + 8'h01;
  end

  // Writing by pointer slot means later bytes overwrite the oldest ones.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pageValid <= '0;
      pageBase  <= '0;
      for (int i = 0; i < PAGE_BYTES; i++)
        pageData[i] <= '0;
    end
    else if (storeByte)
    begin
      pageData[ptr[2:0]]  <= rxShift;
      pageValid[ptr[2:0]] <= 1'b1;
      pageBase            <= ptr[7:3];
    end
    else if (commitDone || (!committing && (startEv || (stopEv && !commitGo))))
      pageValid <= '0;
  end

  assign commitGo = stopEv && (|pageValid) && !wpB && !busy;

  assign commitPush    = committing && pageValid[commitIdx];
  assign commitAdvance = committing && (!pageValid[commitIdx] || fifoInReady);
  assign commitDone    = commitAdvance && (commitIdx == LAST_PAGE_IDX);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      committing <= 1'b0;
      commitIdx  <= '0;
    end
    else if (commitGo)
    begin
      committing <= 1'b1;
      commitIdx  <= '0;
    end
    else if (commitAdvance)
    begin
      commitIdx <= commitIdx + 3'h1;
      if (commitDone)
        committing <= 1'b0;
    end
  end

  // The array only drains while the write cycle runs, so the loader can stall.
  seis_fifo #(
    .Width (FIFO_W),
    .Depth (FIFO_DEPTH)
  ) uFifo (
    .clk      (clk),
    .rst      (rst),
    .inValid  (commitPush),
    .inReady  (fifoInReady),
    .inData   ({pageBase, commitIdx, pageData[commitIdx]}),
    .outValid (fifoOutValid),
    .outReady (busy),
    .outData  (fifoOutData)
  );

  assign wcEnd = (wcCnt == WC_W'(WriteCycles - 1));

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      busy  <= 1'b0;
      wcCnt <= '0;
    end
    else if (commitGo)
    begin
      busy  <= 1'b1;
      wcCnt <= '0;
    end
    else if (busy)
    begin
      if (!wcEnd)
        wcCnt <= wcCnt + WC_W'(1);
      else if (!committing && !fifoOutValid)
        busy <= 1'b0;
    end
  end

  assign writeBusy = busy;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < MEM_DEPTH; i++)
        mem[i] <= MEM_RESET;
    end
    else if (fifoOutValid && busy)
      mem[fifoOutData[15:8]] <= fifoOutData[7:0];
  end

  sequence sCtrlSeen;
    byteDone && (phase == PH_CTRL);
  endsequence

  sequence sAckDriven;
    (state == ST_ACK) && wantLow;
  endsequence

  chk_start_recv: assert property (@(posedge clk) disable iff (rst)
    startEv |=> (state == ST_RECV) && (bitCnt == 4'h0))
    else $error("start did not open a control byte");
  chk_stop_idle: assert property (@(posedge clk) disable iff (rst)
    stopEv |=> (state == ST_IDLE) && !wantLow)
    else $error("stop did not return to idle");
  chk_ctrl_ack: assert property (@(posedge clk) disable iff (rst)
    (sCtrlSeen and (rxShift[7:4] == CTRL_CODE) && !busy) |=> sAckDriven)
    else $error("matching control byte not acknowledged");
  chk_busy_nack: assert property (@(posedge clk) disable iff (rst)
    (sCtrlSeen and busy) |=> (state == ST_IDLE) && !wantLow)
    else $error("control byte acknowledged while programming");
  chk_foreign_quiet: assert property (@(posedge clk) disable iff (rst)
    (sCtrlSeen and (rxShift[7:4] != CTRL_CODE)) |=> (state == ST_IDLE) ##1 !wantLow)
    else $error("foreign control code not ignored");
  chk_dir_bit: assert property (@(posedge clk) disable iff (rst)
    sCtrlSeen |=> (readOp == $past(rxShift[0])))
    else $error("direction bit decoded wrongly");
  chk_sda_delay: assert property (@(posedge clk) disable iff (rst)
    $changed(sdaOe) |-> $past(holdDone) && !$past(sclF))
    else $error("data line moved too soon after clock fall");
  chk_wc_length: assert property (@(posedge clk) disable iff (rst)
    $fell(busy) |-> ($past(wcCnt) == WC_W'(WriteCycles - 1)))
    else $error("write cycle length wrong");
  chk_wp_block: assert property (@(posedge clk) disable iff (rst)
    (stopEv && wpB && !busy) |=> !busy [*2])
    else $error("write started under protection");
  chk_page_wrap: assert property (@(posedge clk) disable iff (rst)
    storeByte |=> (ptr[7:3] == $past(ptr[7:3])) && (ptr[2:0] == $past(ptr[2:0]) + 3'h1))
    else $error("page pointer did not wrap in page");
  chk_read_next: assert property (@(posedge clk) disable iff (rst)
    loadTx |=> (ptr == $past(ptr) + 8'h01) && (state == ST_SEND))
    else $error("read pointer did not advance");
  chk_nack_release: assert property (@(posedge clk) disable iff (rst)
    ((state == ST_MACK) && !masterAck && sclFall && !startEv && !stopEv)
      |=> (state == ST_IDLE) && !wantLow)
    else $error("line not released after master nack");
endmodule
`default_nettype wire

//--- tb/seis_master_model.sv
`timescale 1ns/10ps
`default_nettype none
module seis_master_model
(
  input  wire logic clk,
  input  wire logic sdaLine,
  output logic      scl,
  output logic      sdaLow
);
  initial
  begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // A long low phase lets the slave drop its acknowledge before a repeated Start.
  task automatic start;
    if (scl == 1'b0)
    begin
      tick(2);
      sdaLow = 1'b0;
      tick(8);
      scl = 1'b1;
    end
    tick(4);
    sdaLow = 1'b1;
    tick(4);
    scl = 1'b0;
  endtask

  task automatic stop;
    tick(2);
    sdaLow = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(4);
    sdaLow = 1'b0;
    tick(4);
  endtask

  // The line is read late in the high phase because the slave answers through its filters.
  task automatic bitIo(input logic b, output logic seen);
    tick(2);
    sdaLow = ~b;
    tick(2);
    scl = 1'b1;
    tick(4);
    seen = sdaLine;
    scl = 1'b0;
  endtask

  task automatic sendByte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bitIo(v[i], s);
    bitIo(1'b1, s);
    ack = ~s;
    // The slave answers through its input filters, so it lets go of its acknowledge
    // only well into the next low phase; the clock waits low until it has.
    tick(8);
  endtask

  task automatic recvByte(input logic ackIt, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bitIo(1'b1, s);
      v[i] = s;
    end
    // The slave is still showing its last data bit here, which would mask a withheld acknowledge.
    tick(8);
    bitIo(~ackIt, s);
  endtask
endmodule
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHECK_EQ(got, exp, msg) \
  begin \
    nCompared++; \
    if ((got) !== (exp)) \
    begin \
      numErrors++; \
      $display("Error at %0t ns: %s", $time, msg); \
    end \
  end
module tb
  import seis_pkg::*;
;
  logic       clk;
  logic       rst;
  logic       wpIn;
  logic       scl;
  logic       mSdaLow;
  logic       sdaOut;
  logic       sdaOe;
  logic       writeBusy;
  wire logic  sdaLine;
  int         numErrors = 0;
  int         nCompared = 0;
  logic       a;
  logic [7:0] v;
  logic [7:0] q[$];

  // The pull-up holds the line high unless some party pulls it low.
  assign sdaLine = ~(mSdaLow | sdaOe);

  seis_slave #(
    .WriteCycles(200),
    .HoldCycles (1)
  ) dut (
    .clk      (clk),
    .rst      (rst),
    .sclIn    (scl),
    .sdaIn    (sdaLine),
    .sdaOut   (sdaOut),
    .sdaOe    (sdaOe),
    .wpIn     (wpIn),
    .writeBusy(writeBusy)
  );

  seis_master_model m (
    .clk    (clk),
    .sdaLine(sdaLine),
    .scl    (scl),
    .sdaLow (mSdaLow)
  );

  initial
  begin
    clk = 1'b0;
  end
  always #10 clk = ~clk;

  task automatic report_and_stop;
    if (numErrors == 0 && nCompared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic waitIdle;
    int n;
    n = 0;
    while (writeBusy !== 1'b0 && n < 250)
    begin
      m.tick(1);
      n++;
    end
    `CHECK_EQ(writeBusy, 1'b0, "write cycle did not end")
  endtask

  task automatic writeSeq(input logic [7:0] addr, input logic [7:0] d[$]);
    m.start();
    m.sendByte(8'hA0, a);
    `CHECK_EQ(a, 1'b1, "write control ack")
    m.sendByte(addr, a);
    `CHECK_EQ(a, 1'b1, "address ack")
    foreach (d[i])
    begin
      m.sendByte(d[i], a);
      `CHECK_EQ(a, 1'b1, "data ack")
    end
    m.stop();
  endtask

  task automatic readAt(input logic [7:0] addr, input int n);
    q = {};
    m.start();
    m.sendByte(8'hA0, a);
    m.sendByte(addr, a);
    m.start();
    m.sendByte(8'hA1, a);
    `CHECK_EQ(a, 1'b1, "read control ack")
    for (int i = 0; i < n; i++)
    begin
      m.recvByte(i < n - 1, v);
      q.push_back(v);
    end
    m.tick(8);
    `CHECK_EQ(sdaOe, 1'b0, "line held after nack")
    m.stop();
  endtask

  task automatic byteWriteTest;
    writeSeq(8'hB5, '{8'hA5});
    m.tick(4);
    `CHECK_EQ(writeBusy, 1'b1, "no write cycle after stop")
    m.start();
    m.sendByte(8'hA0, a);
    `CHECK_EQ(a, 1'b0, "ack while programming")
    m.stop();
    waitIdle();
    readAt(8'hB5, 1);
    `CHECK_EQ(q[0], 8'hA5, "byte write readback")
    m.start();
    m.sendByte(8'hA1, a);
    m.recvByte(1'b0, v);
    `CHECK_EQ(v, MEM_RESET, "current address byte")
    m.stop();
  endtask

  task automatic blockSelectTest;
    for (int i = 0; i < 8; i++)
    begin
      m.start();
      m.sendByte({4'hA, 3'(i), 1'b0}, a);
      `CHECK_EQ(a, 1'b1, "block select ack")
      m.stop();
    end
    m.start();
    m.sendByte(8'hB0, a);
    `CHECK_EQ(a, 1'b0, "foreign code acked")
    m.sendByte(8'hA0, a);
    `CHECK_EQ(a, 1'b0, "traffic after foreign code acked")
    m.stop();
  endtask

  // Ten bytes from slot 6 wrap the page and overwrite the two oldest.
  task automatic pageWrapTest;
    logic [7:0] d[$];
    int k;
    for (int i = 0; i < 10; i++)
      d.push_back(8'h10 + 8'(i));
    writeSeq(8'h1E, d);
    waitIdle();
    readAt(8'h18, 8);
    for (int s = 0; s < 8; s++)
    begin
      k = (s + 2) % 8;
      if (k < 2)
        k += 8;
      `CHECK_EQ(q[s], 8'h10 + 8'(k), "page byte")
    end
    readAt(8'h1C, 1);
    `CHECK_EQ(q[0], 8'h16, "single page byte")
    m.start();
    m.sendByte(8'hA1, a);
    m.recvByte(1'b0, v);
    `CHECK_EQ(v, 8'h17, "current address after nack")
    m.stop();
  endtask

  task automatic protectTest;
    wpIn = 1'b1;
    writeSeq(8'hB5, '{8'h43});
    m.tick(6);
    `CHECK_EQ(writeBusy, 1'b0, "write cycle under protect")
    wpIn = 1'b0;
    readAt(8'hB5, 1);
    `CHECK_EQ(q[0], 8'hA5, "protected byte changed")
  endtask

  task automatic abortTest;
    logic s;
    m.start();
    m.sendByte(8'hA0, a);
    m.sendByte(8'h50, a);
    for (int i = 0; i < 4; i++)
      m.bitIo(1'b0, s);
    m.stop();
    m.tick(6);
    `CHECK_EQ(writeBusy, 1'b0, "partial byte started a write")
    readAt(8'h50, 1);
    `CHECK_EQ(q[0], MEM_RESET, "partial byte written")
  endtask

  initial
  begin
    rst = 1'b1;
    wpIn = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    m.tick(10);
    byteWriteTest();
    blockSelectTest();
    pageWrapTest();
    protectTest();
    abortTest();
    `CHECK_EQ(sdaOut, 1'b0, "data output not open drain")
    report_and_stop();
  end

  initial
  begin
    #1000000;
    numErrors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
